// ---- hdl/mifa_pkg.sv ----
// Purpose: constants and types for the indirect sector memory access port
// Assumes: 8-bit register bus, 16-bit byte addresses, one clock domain
// Notes:   offsets are the bus addresses of the six port registers
package mifa_pkg;
	// ----------------------------------------
	// register offsets
	// ----------------------------------------
	localparam logic [15:0] MIFA_OFS_BYTE0 = 16'hf0e0;
	localparam logic [15:0] MIFA_OFS_BYTE1 = 16'hf0e1;
	localparam logic [15:0] MIFA_OFS_BYTE2 = 16'hf0e2;
	localparam logic [15:0] MIFA_OFS_BYTE3 = 16'hf0e3;
	localparam logic [15:0] MIFA_OFS_ADRL  = 16'hf0e4;
	localparam logic [15:0] MIFA_OFS_ADRH  = 16'hf0e5;
	// ----------------------------------------
	// field positions and reset values
	// ----------------------------------------
	localparam int          MIFA_BIT_BUSY  = 6;
	localparam int          MIFA_BIT_DIR   = 7;
	localparam int          MIFA_ADR_W     = 13;
	localparam logic [7:0]  MIFA_RST_BYTE  = 8'h00;
	localparam logic [12:0] MIFA_RST_ADR   = 13'h0000;
	localparam logic [12:0] MIFA_ADR_ONE   = 13'h0001;
	localparam int          MIFA_FIFO_DEP  = 8;
	// ----------------------------------------
	// types
	// ----------------------------------------
	typedef struct packed {
		logic        wr;
		logic [12:0] adr;
		logic [31:0] data;
	} mifa_req_t;
	typedef enum logic [1:0] {
		MIFA_IDLE,
		MIFA_WRITE,
		MIFA_READ
	} mifa_state_t;
endpackage

// ---- hdl/mifa_fifo.sv ----
// Purpose: small synchronous FIFO with valid/ready on both sides
// Assumes: single clock, depth a power of two
// Notes:   holds memory requests on their way to the sector memory
`timescale 1ns/1ps
`default_nettype none
module mifa_fifo #(
	parameter int W = 46,
	parameter int D = 8
) (
	input  wire logic         clk_i,
	input  wire logic         reset_i,
	input  wire logic         en_i,
	input  wire logic         in_valid_i,
	output logic              in_ready_o,
	input  wire logic [W-1:0] in_data_i,
	output logic              out_valid_o,
	input  wire logic         out_ready_i,
	output logic      [W-1:0] out_data_o
);
	localparam int AW = $clog2(D);
	logic [W-1:0] mem [D];
	logic [AW:0]  wp;
	logic [AW:0]  rp;
	wire          push = en_i && in_valid_i && in_ready_o;
	wire          pop  = en_i && out_valid_o && out_ready_i;
	// honest full and empty from extended pointers
	assign in_ready_o  = (wp - rp) != (AW+1)'(D);
	assign out_valid_o = wp != rp;
	assign out_data_o  = mem[rp[AW-1:0]];
	// storage
	always_ff @(posedge clk_i) begin
		if (push) begin
			mem[wp[AW-1:0]] <= in_data_i;
		end
	end
	// pointers
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			wp <= '0;
			rp <= '0;
		end else begin
			if (push) begin
				wp <= wp + 1'b1;
			end
			if (pop) begin
				rp <= rp + 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

// ---- hdl/mifa_port.sv ----
// Purpose: MCU indirect access port into sector FIFO memory, word at a time
// Assumes: memory answers reads with mem_rvalid_i, writes with mem_wdone_i
// Notes:   requests pass a FIFO; busy covers the whole memory transfer
`timescale 1ns/1ps
`default_nettype none
module mifa_port
	import mifa_pkg::*;
#(
	parameter int FIFO_DEPTH = MIFA_FIFO_DEP
) (
	input  wire logic        clk_i,
	input  wire logic        reset_i,
	input  wire logic        clk_en_i,
	input  wire logic [15:0] bus_addr_i,
	input  wire logic        bus_wr_i,
	input  wire logic        bus_rd_i,
	input  wire logic [7:0]  bus_wdata_i,
	output logic      [7:0]  bus_rdata_o,
	output logic             mem_valid_o,
	input  wire logic        mem_ready_i,
	output logic             mem_wr_o,
	output logic      [12:0] mem_addr_o,
	output logic      [31:0] mem_wdata_o,
	input  wire logic        mem_wdone_i,
	input  wire logic        mem_rvalid_i,
	input  wire logic [31:0] mem_rdata_i
);
	// ----------------------------------------
	// register state
	// ----------------------------------------
	logic [7:0]  lane [4];
	logic [12:0] word_adr;
	logic        dir;
	logic        busy;
	mifa_state_t state;
	logic [7:0]  rdata;
	logic        mvalid;
	logic        mwr;
	logic [12:0] maddr;
	logic [31:0] mwdata;

	// ----------------------------------------
	// address decode
	// ----------------------------------------
	function automatic logic hit(input logic [15:0] a, input logic [15:0] ofs);
		hit = (a == ofs);
	endfunction
	wire wr_b3  = clk_en_i && bus_wr_i && hit(bus_addr_i, MIFA_OFS_BYTE3);
	wire rd_b3  = clk_en_i && bus_rd_i && hit(bus_addr_i, MIFA_OFS_BYTE3);
	wire wr_adl = clk_en_i && bus_wr_i && hit(bus_addr_i, MIFA_OFS_ADRL);
	wire wr_adh = clk_en_i && bus_wr_i && hit(bus_addr_i, MIFA_OFS_ADRH);
	wire new_dir = bus_wdata_i[MIFA_BIT_DIR];

	// ----------------------------------------
	// request path through the FIFO
	// ----------------------------------------
	mifa_req_t   q_in;
	mifa_req_t   q_out;
	logic        q_in_ready;
	logic        q_out_valid;
	logic        mem_idle;
	// store word on byte 3 write
	wire start_wr = wr_b3 && !dir && !busy && q_in_ready;
	// prefetch on high write with dir 1, or byte 3 read only
	wire start_rd = ((wr_adh && new_dir) || (rd_b3 && dir)) && !busy && q_in_ready;
	assign q_in.wr   = start_wr;
	// a read started by the high byte must use the high bits just written
	assign q_in.adr  = wr_adh ? {bus_wdata_i[4:0], word_adr[7:0]} : word_adr;
	assign q_in.data = {bus_wdata_i, lane[2], lane[1], lane[0]};
	assign mem_idle  = !mvalid;

	mifa_fifo #(
		.W ($bits(mifa_req_t)),
		.D (FIFO_DEPTH)
	) u_fifo (
		.clk_i       (clk_i),
		.reset_i     (reset_i),
		.en_i        (clk_en_i),
		.in_valid_i  (start_wr || start_rd),
		.in_ready_o  (q_in_ready),
		.in_data_i   (q_in),
		.out_valid_o (q_out_valid),
		.out_ready_i (mem_idle),
		.out_data_o  (q_out)
	);

	// memory request register, one outstanding transfer
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			mvalid <= 1'b0;
			mwr    <= 1'b0;
			maddr  <= MIFA_RST_ADR;
			mwdata <= '0;
		end else if (clk_en_i) begin
			if (mvalid && mem_ready_i) begin
				mvalid <= 1'b0;
			end else if (q_out_valid && mem_idle) begin
				mvalid <= 1'b1;
				mwr    <= q_out.wr;
				maddr  <= q_out.adr;
				mwdata <= q_out.data;
			end
		end
	end
	assign mem_valid_o = mvalid;
	assign mem_wr_o    = mwr;
	assign mem_addr_o  = maddr;
	assign mem_wdata_o = mwdata;

	// ----------------------------------------
	// transfer sequencer
	// ----------------------------------------
	wire done_wr = (state == MIFA_WRITE) && mem_wdone_i;
	wire done_rd = (state == MIFA_READ) && mem_rvalid_i;
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			state <= MIFA_IDLE;
			busy  <= 1'b0;
		end else if (clk_en_i) begin
			case (state)
				MIFA_IDLE: begin
					if (start_wr) begin
						state <= MIFA_WRITE;
						busy  <= 1'b1;
					end else if (start_rd) begin
						state <= MIFA_READ;
						busy  <= 1'b1;
					end
				end
				MIFA_WRITE: begin
					if (mem_wdone_i) begin
						state <= MIFA_IDLE;
						busy  <= 1'b0;
					end
				end
				MIFA_READ: begin
					if (mem_rvalid_i) begin
						state <= MIFA_IDLE;
						busy  <= 1'b0;
					end
				end
				default: begin
					state <= MIFA_IDLE;
					busy  <= 1'b0;
				end
			endcase
		end
	end

	// ----------------------------------------
	// address and direction
	// ----------------------------------------
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			word_adr <= MIFA_RST_ADR;
			dir      <= 1'b0;
		end else if (clk_en_i) begin
			// low byte, high five bits, carrying increment
			if (wr_adl && !busy) begin
				word_adr[7:0] <= bus_wdata_i;
			end else if (wr_adh && !busy) begin
				word_adr[12:8] <= bus_wdata_i[4:0];
				dir            <= new_dir;
			end else if (done_wr || done_rd) begin
				word_adr <= word_adr + MIFA_ADR_ONE;
			end
		end
	end

	// ----------------------------------------
	// data lanes
	// ----------------------------------------
	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_lane
			wire wr_me = clk_en_i && bus_wr_i && !busy && !dir
				&& hit(bus_addr_i, MIFA_OFS_BYTE0 + 16'(g));
			always_ff @(posedge clk_i or posedge reset_i) begin
				if (reset_i) begin
					lane[g] <= MIFA_RST_BYTE;
				end else if (clk_en_i) begin
					if (done_rd) begin
						lane[g] <= mem_rdata_i[8*g +: 8];
					end else if (wr_me) begin
						lane[g] <= bus_wdata_i;
					end
				end
			end
		end
	endgenerate

	// ----------------------------------------
	// read data mux, registered
	// ----------------------------------------
	logic [7:0] next_rdata;
	always_comb begin
		next_rdata = 8'h00;
		case (bus_addr_i)
			MIFA_OFS_BYTE0: next_rdata = lane[0];
			MIFA_OFS_BYTE1: next_rdata = lane[1];
			MIFA_OFS_BYTE2: next_rdata = lane[2];
			MIFA_OFS_BYTE3: next_rdata = lane[3];
			MIFA_OFS_ADRL:  next_rdata = word_adr[7:0];
			// busy at bit 6, reserved bit 5 zero
			MIFA_OFS_ADRH:  next_rdata = {dir, busy, 1'b0, word_adr[12:8]};
			default:        next_rdata = 8'h00;
		endcase
	end
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			rdata <= 8'h00;
		end else if (clk_en_i && bus_rd_i) begin
			rdata <= next_rdata;
		end
	end
	assign bus_rdata_o = rdata;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	AST_WR_BUSY: assert property (@(posedge clk_i) disable iff (reset_i)
		start_wr |=> busy && state == MIFA_WRITE)
		else $error("byte 3 write did not set busy");
	AST_WR_DONE: assert property (@(posedge clk_i) disable iff (reset_i)
		(clk_en_i && done_wr && !wr_adl && !wr_adh) |=> !busy
			&& word_adr == $past(word_adr) + MIFA_ADR_ONE)
		else $error("write done did not free busy and bump address");
	AST_RD_START: assert property (@(posedge clk_i) disable iff (reset_i)
		(wr_adh && new_dir && !busy && q_in_ready) |=> busy && dir)
		else $error("read setup did not start a prefetch");
	AST_RD_LOAD: assert property (@(posedge clk_i) disable iff (reset_i)
		(clk_en_i && done_rd) |=> !busy && lane[3] == $past(mem_rdata_i[31:24]))
		else $error("fetched word not loaded");
	AST_NO_ADV: assert property (@(posedge clk_i) disable iff (reset_i)
		(state == MIFA_IDLE && !wr_adh && !(rd_b3 && dir) && !start_wr) |=> !busy)
		else $error("prefetch without byte 3 read");
	AST_RD_NEXT: assert property (@(posedge clk_i) disable iff (reset_i)
		(rd_b3 && dir && !busy && q_in_ready) |=> state == MIFA_READ)
		else $error("byte 3 read did not prefetch");
	AST_BUSY_BIT: assert property (@(posedge clk_i) disable iff (reset_i)
		(clk_en_i && bus_rd_i && bus_addr_i == MIFA_OFS_ADRH) |=>
			bus_rdata_o[MIFA_BIT_BUSY] == $past(busy) && bus_rdata_o[5] == 1'b0)
		else $error("busy bit not shown at bit 6");
	AST_DIR_BIT: assert property (@(posedge clk_i) disable iff (reset_i)
		(wr_adh && !busy) |=> dir == $past(bus_wdata_i[MIFA_BIT_DIR]))
		else $error("direction bit not taken");
	AST_ADR_SPLIT: assert property (@(posedge clk_i) disable iff (reset_i)
		(wr_adl && !busy) |=> word_adr[7:0] == $past(bus_wdata_i))
		else $error("low address byte not stored");
	// ----------------------------------------
	// request and refusal checks
	// ----------------------------------------
	AST_WR_REQ: assert property (@(posedge clk_i) disable iff (reset_i)
		start_wr ##1 clk_en_i |=> mem_valid_o && mem_wr_o && mem_addr_o == word_adr
			&& mem_wdata_o[31:24] == lane[3])
		else $error("stored word request malformed");
	AST_RD_ADR: assert property (@(posedge clk_i) disable iff (reset_i)
		(wr_adh && new_dir && !busy && q_in_ready) ##1 clk_en_i
			|=> mem_valid_o && !mem_wr_o && mem_addr_o == word_adr)
		else $error("prefetch request not at the written address");
	AST_REQ_HOLD: assert property (@(posedge clk_i) disable iff (reset_i)
		(mem_valid_o && !mem_ready_i) |=> mem_valid_o && $stable(mem_addr_o)
			&& $stable(mem_wr_o))
		else $error("memory request dropped before acceptance");
	AST_FREEZE: assert property (@(posedge clk_i) disable iff (reset_i)
		!clk_en_i |=> $stable(word_adr) && $stable(dir) && $stable(busy)
			&& $stable(mem_valid_o) && $stable(bus_rdata_o))
		else $error("state moved while the clock enable was low");
	AST_DATA_REFUSE: assert property (@(posedge clk_i) disable iff (reset_i)
		(clk_en_i && bus_wr_i && (dir || busy) && bus_addr_i == MIFA_OFS_BYTE0 && !done_rd)
			|=> $stable(lane[0]))
		else $error("data byte write taken in read direction or while busy");
	AST_ADR_BUSY: assert property (@(posedge clk_i) disable iff (reset_i)
		(busy && !done_wr && !done_rd) |=> $stable(word_adr))
		else $error("access address moved during a transfer");
	AST_LANE_WR: assert property (@(posedge clk_i) disable iff (reset_i)
		(clk_en_i && bus_wr_i && !busy && !dir && bus_addr_i == MIFA_OFS_BYTE1) |=>
			lane[1] == $past(bus_wdata_i))
		else $error("data byte 1 write not stored");
	AST_UNMAPPED: assert property (@(posedge clk_i) disable iff (reset_i)
		(clk_en_i && bus_rd_i && bus_addr_i == MIFA_OFS_ADRH + 16'h0001)
			|=> bus_rdata_o == 8'h00)
		else $error("unmapped register read not zero");
endmodule
`default_nettype wire

// ---- testbench/mifa_mem_model.sv ----
// Purpose: behavioural sector memory answering the port's requests
// Assumes: one request outstanding; answers only after acceptance
// Notes:   random ready and answer delays; read data scrambled when idle
`timescale 1ns/1ps
`default_nettype none
module mifa_mem_model (
	input  wire logic        clk_i,
	input  wire logic        mem_valid_i,
	input  wire logic        mem_wr_i,
	input  wire logic [12:0] mem_addr_i,
	input  wire logic [31:0] mem_wdata_i,
	output logic             mem_ready_o,
	output logic             mem_wdone_o,
	output logic             mem_rvalid_o,
	output logic      [31:0] mem_rdata_o
);
	logic [31:0] mem [0:8191];
	logic        req_wr;
	logic [12:0] req_adr;
	// ----------------------------------------
	// request service loop
	// ----------------------------------------
	initial begin
		for (int i = 0; i < 8192; i++) begin
			mem[i] = 32'hc3c3_0000 ^ 32'(i);
		end
		mem_ready_o  = 1'b0;
		mem_wdone_o  = 1'b0;
		mem_rvalid_o = 1'b0;
		mem_rdata_o  = 32'h5a5a_a5a5;
		forever begin
			@(posedge clk_i iff mem_valid_i === 1'b1);
			repeat ($urandom_range(0, 3)) @(posedge clk_i);
			#1 mem_ready_o = 1'b1;
			@(posedge clk_i);
			req_wr  = mem_wr_i;
			req_adr = mem_addr_i;
			if (req_wr) begin
				mem[req_adr] = mem_wdata_i;
			end
			#1 mem_ready_o = 1'b0;
			repeat ($urandom_range(0, 3)) @(posedge clk_i);
			#1 mem_wdone_o = req_wr;
			mem_rvalid_o = !req_wr;
			mem_rdata_o  = req_wr ? ~mem_rdata_o : mem[req_adr];
			@(posedge clk_i);
			#1 mem_wdone_o = 1'b0;
			mem_rvalid_o = 1'b0;
			mem_rdata_o  = ~mem_rdata_o; // no stale data after the pulse
		end
	end
endmodule
`default_nettype wire

// ---- testbench/mcu_indirect_fifo_access_port_tb.sv ----
// Purpose: self-checking bench for the indirect sector memory port
// Assumes: bus inputs change at the falling edge
// Notes:   random words and addresses from a fixed seed
`timescale 1ns/1ps
`default_nettype none
module mcu_indirect_fifo_access_port_tb;
	import mifa_pkg::*;
	logic        clk_i, reset_i, bus_wr_i, bus_rd_i, mem_valid_o, mem_wr_o;
	logic        mem_ready_i, mem_wdone_i, mem_rvalid_i;
	logic        clk_en_i;
	logic [15:0] bus_addr_i;
	logic [7:0]  bus_wdata_i, bus_rdata_o, v;
	logic [12:0] mem_addr_o;
	logic [31:0] mem_wdata_o, mem_rdata_i;
	logic [31:0] words [0:7];
	int          err_total, cmp_count, cyc;
	mifa_port i_dut (.clk_i(clk_i), .reset_i(reset_i), .clk_en_i(clk_en_i),
		.bus_addr_i(bus_addr_i), .bus_wr_i(bus_wr_i), .bus_rd_i(bus_rd_i),
		.bus_wdata_i(bus_wdata_i), .bus_rdata_o(bus_rdata_o), .mem_valid_o(mem_valid_o),
		.mem_ready_i(mem_ready_i), .mem_wr_o(mem_wr_o), .mem_addr_o(mem_addr_o),
		.mem_wdata_o(mem_wdata_o), .mem_wdone_i(mem_wdone_i),
		.mem_rvalid_i(mem_rvalid_i), .mem_rdata_i(mem_rdata_i));
	mifa_mem_model i_mem (.clk_i(clk_i), .mem_valid_i(mem_valid_o), .mem_wr_i(mem_wr_o),
		.mem_addr_i(mem_addr_o), .mem_wdata_i(mem_wdata_o), .mem_ready_o(mem_ready_i),
		.mem_wdone_o(mem_wdone_i), .mem_rvalid_o(mem_rvalid_i), .mem_rdata_o(mem_rdata_i));
	// ----------------------------------------
	// clock, timeout and shared tasks
	// ----------------------------------------
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 60000) begin
			err_total++;
			$display("[FAIL] %0t: run did not finish", $time);
			end_of_test();
		end
	end
	task automatic end_of_test();
		$display("compares %0d, mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			err_total++;
			$display("[FAIL] %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic bus_wr(input logic [15:0] a, input logic [7:0] d);
		@(negedge clk_i);
		bus_addr_i  = a;
		bus_wdata_i = d;
		bus_wr_i    = 1'b1;
		@(negedge clk_i);
		bus_wr_i = 1'b0;
	endtask
	task automatic bus_rd(input logic [15:0] a, output logic [7:0] d);
		@(negedge clk_i);
		bus_addr_i = a;
		bus_rd_i   = 1'b1;
		@(negedge clk_i);
		bus_rd_i = 1'b0;
		d        = bus_rdata_o;
	endtask
	// poll busy flag; returns its first reading
	task automatic wait_idle(output logic first);
		int n;
		bus_rd(MIFA_OFS_ADRH, v);
		first = v[MIFA_BIT_BUSY];
		for (n = 0; n < 100 && v[MIFA_BIT_BUSY] !== 1'b0; n++) bus_rd(MIFA_OFS_ADRH, v);
		chk(32'(v[MIFA_BIT_BUSY]), 32'h0000_0000);
	endtask
	// expected contents of the high address register when idle
	function automatic logic [7:0] adrh_exp(input logic [12:0] a, input logic dir);
		return {dir, 2'b00, a[12:8]};
	endfunction
	// address low then high with direction
	task automatic set_adr(input logic [12:0] a, input logic dir);
		bus_wr(MIFA_OFS_ADRL, a[7:0]);
		bus_wr(MIFA_OFS_ADRH, adrh_exp(a, dir));
	endtask
	task automatic chk_adr(input logic [12:0] a, input logic dir);
		bus_rd(MIFA_OFS_ADRL, v);
		chk(32'(v), 32'(a[7:0]));
		bus_rd(MIFA_OFS_ADRH, v);
		chk(32'(v), 32'(adrh_exp(a, dir)));
	endtask
	// ----------------------------------------
	// write a burst, then read it back
	// ----------------------------------------
	task automatic burst(input logic [12:0] a, input int n);
		logic b;
		set_adr(a, 1'b0);
		for (int i = 0; i < n; i++) begin
			words[i] = $urandom;
			for (int k = 0; k < 4; k++) bus_wr(MIFA_OFS_BYTE0 + 16'(k), words[i][8*k+:8]);
			// an address write during the store is ignored
			bus_wr(MIFA_OFS_ADRL, ~a[7:0]);
			wait_idle(b);
			chk(32'(b), 32'h0000_0001);
		end
		chk_adr(a + 13'(n), 1'b0);
		for (int i = 0; i < n; i++) chk(i_mem.mem[a + 13'(i)], words[i]);
		set_adr(a, 1'b1);
		wait_idle(b);
		chk(32'(b), 32'h0000_0001);
		for (int i = 0; i < n; i++) begin
			// bytes in order, word 1 skips bytes 1 and 2
			for (int k = 0; k < 3; k++) begin
				if (i != 1 || k == 0) begin
					bus_rd(MIFA_OFS_BYTE0 + 16'(k), v);
					chk(32'(v), 32'(words[i][8*k+:8]));
				end
			end
			bus_wr(MIFA_OFS_BYTE0, ~words[i][7:0]);
			bus_rd(MIFA_OFS_BYTE0, v);
			chk(32'(v), 32'(words[i][7:0]));
			chk_adr(a + 13'(i + 1), 1'b1);
			bus_rd(MIFA_OFS_BYTE3, v);
			chk(32'(v), 32'(words[i][31:24]));
			wait_idle(b);
			chk(32'(b), 32'h0000_0001);
		end
		chk_adr(a + 13'(n + 1), 1'b1);
	endtask
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		reset_i     = 1'b1;
		clk_en_i    = 1'b1;
		bus_wr_i    = 1'b0;
		bus_rd_i    = 1'b0;
		bus_addr_i  = 16'h0000;
		bus_wdata_i = 8'h00;
		void'($urandom(32'h494b));
		repeat (12) @(negedge clk_i);
		reset_i = 1'b0;
		for (int k = 0; k < 7; k++) begin
			bus_rd(MIFA_OFS_BYTE0 + 16'(k), v);
			chk(32'(v), 32'(MIFA_RST_BYTE));
		end
		$display("reset values test done");
		// register writes are lost while the clock enable is low
		set_adr(13'h0a5c, 1'b0);
		@(negedge clk_i);
		clk_en_i = 1'b0;
		set_adr(13'h1234, 1'b1);
		@(negedge clk_i);
		clk_en_i = 1'b1;
		chk_adr(13'h0a5c, 1'b0);
		$display("clock enable test done");
		burst(13'h00ff, 3);
		burst(13'h1ffe, 3);
		$display("address boundary test done");
		repeat (4) burst(13'($urandom_range(0, 8191)), $urandom_range(1, 4));
		$display("random burst test done");
		@(negedge clk_i);
		reset_i = 1'b1;
		repeat (2) @(negedge clk_i);
		reset_i = 1'b0;
		chk_adr(MIFA_RST_ADR, 1'b0);
		$display("second reset test done");
		end_of_test();
	end
endmodule
`default_nettype wire
